// >>> pfkbi_pkg.sv
// Package for the port F keyboard interrupt block.
// Assumes a 32-bit Avalon-MM register port and an 8-pin port.
package pfkbi_pkg;

  // ****************************************
  // Register map (word byte addresses)
  // ****************************************
  localparam logic [3:0] ADDR_STATUS_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_PIN_ENABLE     = 4'h4;
  localparam logic [3:0] ADDR_PULLUP_ENABLE  = 4'h8;
  localparam logic [3:0] ADDR_DIRECTION      = 4'hC;

  // ****************************************
  // Status and control fields
  // ****************************************
  localparam int BIT_SENSITIVITY = 0;
  localparam int BIT_MASK        = 1;
  localparam int BIT_ACK         = 2;
  localparam int BIT_PENDING     = 3;

  // ****************************************
  // Reset values and vector
  // ****************************************
  localparam logic [7:0]  RST_PIN_ENABLE = 8'h00;
  localparam logic [7:0]  RST_PULLUP     = 8'hFF;
  localparam logic [7:0]  RST_DIRECTION  = 8'h00;
  localparam logic [15:0] KEYPAD_VECTOR  = 16'hFFE8;
  localparam logic [31:0] READ_ZERO      = 32'h0000_0000;

  // Trigger sensitivity
  typedef enum logic {
    SENS_EDGE,
    SENS_EDGE_LEVEL
  } pfkbi_sens_e;

  // Core-side interrupt signals
  typedef struct packed {
    logic        irq;
    logic        wake;
    logic [15:0] vector;
  } pfkbi_cpu_s;

endpackage : pfkbi_pkg

// >>> pfkbi_top.sv
// Port F keyboard interrupt controller with Avalon-MM register port.
// Assumes keypad pins are asynchronous; vector fetch and break state
// arrive on the bus clock.
//
// Function
// RULE1 - Each of eight pins has its own keyboard interrupt enable bit.
// RULE2 - Pull-ups follow only the pull-up enable bits, not the interrupt enables.
// RULE3 - Low level on an enabled pin latches a keyboard request.
// RULE4 - Request latches when enabled pins go low after all were high.
// RULE5 - Edge mode: no new request while another enabled pin is low.
// RULE6 - Edge-and-level mode: request held while any enabled pin is low.
// RULE7 - Level mode clears only after acknowledge and all pins high, any order.
// RULE8 - Vector fetch produces an acknowledge that clears the request.
// RULE9 - Writing one to the write-only acknowledge bit clears; reads zero.
// RULE10 - Falling edge after a software acknowledge latches a new request.
// RULE11 - Unmasked request gives the core the vector at FFE8/FFE9.
// RULE12 - Edge mode: acknowledge clears the request at once.
// RULE13 - Reset clears request and sensitivity bit even with a pin low.
// RULE14 - Read-only pending flag shows the request regardless of the mask.
// RULE15 - An enabled keyboard pin is forced to input over its direction bit.
// RULE16 - Software masks, sets inputs, enables, acknowledges, then unmasks.
// RULE17 - Software delays level-mode acknowledge until the pull-up charges the pin.
// RULE18 - Status and control bits 7 to 4 read as zero.
// RULE19 - Mask bit blocks the interrupt; reset clears the mask.
// RULE20 - Reset enables all eight pull-ups.
// RULE21 - Block stays active in wait and stop; unmasked request wakes core.
// RULE22 - In break with break-clear enable low, acknowledge writes are ignored.
// RULE23 - With break-clear enable high, break acknowledge clears and stays cleared.
// RULE24 - Each pin passes two flip-flops before any detection logic.
//
// The Avalon-MM slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps

module pfkbi_top
  import pfkbi_pkg::*;
#(
  parameter int PINS = 8
) (
  // Clock and reset
  input  wire logic              CLK_IN,
  input  wire logic              SYS_RST_IN,
  // Avalon-MM slave
  input  wire logic [3:0]        AVS_ADDRESS_IN,
  input  wire logic              AVS_READ_IN,
  input  wire logic              AVS_WRITE_IN,
  input  wire logic [31:0]       AVS_WRITEDATA_IN,
  input  wire logic [3:0]        AVS_BYTEENABLE_IN,
  output logic      [31:0]       AVS_READDATA_OUT,
  output logic                   AVS_WAITREQUEST_OUT,
  // Core and system integration
  input  wire logic              VECTOR_FETCH_IN,
  input  wire logic              BREAK_STATE_IN,
  input  wire logic              BREAK_CLEAR_ENABLE_IN,
  output pfkbi_pkg::pfkbi_cpu_s  CPU_OUT,
  // Port pins
  input  wire logic [PINS-1:0]   PIN_IN,
  output logic      [PINS-1:0]   PIN_PULLUP_OUT,
  output logic      [PINS-1:0]   PIN_OUTPUT_ENABLE_OUT
);
  import pfkbi_pkg::*;

  // ****************************************
  // Registers
  // ****************************************
  logic [PINS-1:0] sync1_q, sync2_q;
  logic [PINS-1:0] irq_en_q, irq_en_d;
  logic [PINS-1:0] pullup_q, pullup_d;
  logic [PINS-1:0] dir_q, dir_d;
  pfkbi_sens_e     sens_q, sens_d;
  logic            mask_q, mask_d;
  logic            req_q, req_d;
  logic            any_low_q;
  logic            acked_q, acked_d;
  logic            rsp_q;
  logic [31:0]     rdata_q, rdata_d;
  pfkbi_cpu_s      cpu_q, cpu_d;

  // ****************************************
  // Bus decode
  // ****************************************
  wire       access   = (AVS_READ_IN | AVS_WRITE_IN) & ~rsp_q;
  // Write lands on the answer edge, when waitrequest is low
  wire       wr       = AVS_WRITE_IN & rsp_q & AVS_BYTEENABLE_IN[0];
  wire       sel_sc   = (AVS_ADDRESS_IN == ADDR_STATUS_CONTROL);
  wire       sel_ie   = (AVS_ADDRESS_IN == ADDR_PIN_ENABLE);
  wire       sel_pu   = (AVS_ADDRESS_IN == ADDR_PULLUP_ENABLE);
  wire       sel_dir  = (AVS_ADDRESS_IN == ADDR_DIRECTION);
  wire [7:0] wbyte    = AVS_WRITEDATA_IN[7:0];

  // Software acknowledge, gated during protected break
  wire sw_ack = wr & sel_sc & wbyte[BIT_ACK]
              & (~BREAK_STATE_IN | BREAK_CLEAR_ENABLE_IN);      // [RULE9] [RULE22] [RULE23]
  wire ack    = sw_ack | VECTOR_FETCH_IN;                       // [RULE8]

  // ****************************************
  // Keyboard detection
  // ****************************************
  wire [PINS-1:0] low_en = ~sync2_q & irq_en_q;                 // [RULE1] [RULE3]
  wire            any_low = |low_en;
  wire            fall    = any_low & ~any_low_q;               // [RULE4] [RULE5] [RULE10]
  wire            level   = (sens_q == SENS_EDGE_LEVEL);

  always_comb begin
    req_d   = req_q;
    acked_d = acked_q;
    if (fall) begin
      req_d   = 1'b1;                                           // [RULE4]
      acked_d = 1'b0;
    end else if (ack && !level) begin
      req_d = 1'b0;                                             // [RULE12]
    end else if (level) begin
      if (ack) begin
        acked_d = 1'b1;
      end
      if ((ack || acked_q) && !any_low) begin
        req_d   = 1'b0;                                         // [RULE7]
        acked_d = 1'b0;
      end else if (any_low && !(ack || acked_q)) begin
        req_d = 1'b1;                                           // [RULE6]
      end
    end
  end

  // ****************************************
  // Register writes
  // ****************************************
  assign irq_en_d = (wr && sel_ie)  ? wbyte[PINS-1:0] : irq_en_q;
  assign pullup_d = (wr && sel_pu)  ? wbyte[PINS-1:0] : pullup_q;  // [RULE2]
  assign dir_d    = (wr && sel_dir) ? wbyte[PINS-1:0] : dir_q;
  assign sens_d   = (wr && sel_sc)  ? pfkbi_sens_e'(wbyte[BIT_SENSITIVITY]) : sens_q;
  assign mask_d   = (wr && sel_sc)  ? wbyte[BIT_MASK] : mask_q;

  // ****************************************
  // Read data
  // ****************************************
  wire [7:0] sc_read = {4'h0, req_q, 1'b0, mask_q, sens_q};     // [RULE14] [RULE18]
  always_comb begin
    rdata_d = READ_ZERO;
    if (AVS_READ_IN && !rsp_q) begin
      case (1'b1)
        sel_sc:  rdata_d = {24'h00_0000, sc_read};
        sel_ie:  rdata_d = {24'h00_0000, 8'(irq_en_q)};
        sel_pu:  rdata_d = {24'h00_0000, 8'(pullup_q)};
        sel_dir: rdata_d = {24'h00_0000, 8'(dir_q)};
        default: rdata_d = READ_ZERO;
      endcase
    end
  end

  // Interrupt toward the core
  assign cpu_d = '{irq: req_q & ~mask_q,                        // [RULE19] [RULE11]
                   wake: req_q & ~mask_q,                       // [RULE21]
                   vector: KEYPAD_VECTOR};

  // ****************************************
  // Flip-flops
  // ****************************************
  always_ff @(posedge CLK_IN) begin
    sync1_q <= PIN_IN;                                          // [RULE24]
    sync2_q <= sync1_q;                                         // [RULE24]
  end

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      irq_en_q  <= RST_PIN_ENABLE[PINS-1:0];
      pullup_q  <= RST_PULLUP[PINS-1:0];                        // [RULE20]
      dir_q     <= RST_DIRECTION[PINS-1:0];
      sens_q    <= SENS_EDGE;                                   // [RULE13]
      mask_q    <= 1'b0;                                        // [RULE19]
      req_q     <= 1'b0;                                        // [RULE13]
      acked_q   <= 1'b0;
      any_low_q <= 1'b1;
      rsp_q     <= 1'b0;
      rdata_q   <= READ_ZERO;
      cpu_q     <= '0;
    end else begin
      irq_en_q  <= irq_en_d;
      pullup_q  <= pullup_d;
      dir_q     <= dir_d;
      sens_q    <= sens_d;
      mask_q    <= mask_d;
      req_q     <= req_d;
      acked_q   <= acked_d;
      any_low_q <= any_low;
      rsp_q     <= access;
      rdata_q   <= rdata_d;
      cpu_q     <= cpu_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  logic [PINS-1:0] oe_q;
  logic [PINS-1:0] pu_q;
  logic            wait_q;
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      oe_q   <= '0;
      pu_q   <= RST_PULLUP[PINS-1:0];
      wait_q <= 1'b1;
    end else begin
      oe_q   <= dir_d & ~irq_en_d;                              // [RULE15]
      pu_q   <= pullup_d;                                       // [RULE2]
      wait_q <= ~access;
    end
  end

  assign AVS_READDATA_OUT      = rdata_q;
  assign AVS_WAITREQUEST_OUT   = wait_q;
  assign CPU_OUT               = cpu_q;
  assign PIN_PULLUP_OUT        = pu_q;
  assign PIN_OUTPUT_ENABLE_OUT = oe_q;

endmodule : pfkbi_top

// >>> pfkbi_props.sv
// Checker for the port F keypad interrupt block.
// Sees only top-level ports; bound to pfkbi_top below.
`timescale 1ns/1ps
module pfkbi_props
  import pfkbi_pkg::*;
#(parameter int PINS = 8) (
  // Watched ports
  input wire logic            CLK_IN,
  input wire logic            SYS_RST_IN,
  input wire logic [3:0]      AVS_ADDRESS_IN,
  input wire logic            AVS_READ_IN,
  input wire logic            AVS_WRITE_IN,
  input wire logic [31:0]     AVS_READDATA_OUT,
  input wire logic            AVS_WAITREQUEST_OUT,
  input wire pfkbi_cpu_s      CPU_OUT,
  input wire logic [PINS-1:0] PIN_IN,
  input wire logic [PINS-1:0] PIN_PULLUP_OUT,
  input wire logic [PINS-1:0] PIN_OUTPUT_ENABLE_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  wire req = AVS_READ_IN | AVS_WRITE_IN;
  wire ans = ~AVS_WAITREQUEST_OUT;
  bus_answer_a: assert property (req && !ans |=> ans)
    else $error("bus answer late");
  answer_pulse_a: assert property (ans |=> !ans)
    else $error("answer longer than one cycle");
  upper_zero_a: assert property (ans |-> AVS_READDATA_OUT[31:8] == 24'h0)
    else $error("read data upper bits set");
  status_bits_a:
    assert property (ans && AVS_READ_IN && AVS_ADDRESS_IN == ADDR_STATUS_CONTROL
      |-> AVS_READDATA_OUT[7:4] == 4'h0 && !AVS_READDATA_OUT[2]) else $error("status bits");
  wake_irq_a: assert property (CPU_OUT.wake == CPU_OUT.irq)
    else $error("wake differs from irq");
  irq_vector_a: assert property (CPU_OUT.irq |-> CPU_OUT.vector == 16'hFFE8)
    else $error("wrong vector");
  reset_state_a:
    assert property (disable iff (1'b0) SYS_RST_IN |=> !CPU_OUT.irq && &PIN_PULLUP_OUT
      && PIN_OUTPUT_ENABLE_OUT == '0) else $error("reset state wrong");
  irq_cause_a:
    assert property ($rose(CPU_OUT.irq) |-> ~&$past(PIN_IN, 2) || ~&$past(PIN_IN, 3)
      || ~&$past(PIN_IN, 4) || $past(AVS_WRITE_IN) || $past(AVS_WRITE_IN, 2))
    else $error("irq without cause");
endmodule : pfkbi_props

bind pfkbi_top pfkbi_props #(.PINS(PINS)) pfkbi_props_inst (
  .CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN), .AVS_ADDRESS_IN(AVS_ADDRESS_IN),
  .AVS_READ_IN(AVS_READ_IN), .AVS_WRITE_IN(AVS_WRITE_IN), .CPU_OUT(CPU_OUT),
  .AVS_READDATA_OUT(AVS_READDATA_OUT), .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
  .PIN_IN(PIN_IN), .PIN_PULLUP_OUT(PIN_PULLUP_OUT),
  .PIN_OUTPUT_ENABLE_OUT(PIN_OUTPUT_ENABLE_OUT));

// >>> pfkbi_keys.sv
// Key and pull-up model on the eight port pins.
// Pressed keys pull low; a pin without pull-up floats.
`timescale 1ns/1ps
module pfkbi_keys (
  // Clock, keys and pull-ups
  input  wire logic       clk_in,
  input  wire logic [7:0] press_in,
  input  wire logic [7:0] pullup_in,
  // Pin levels
  output logic      [7:0] pin_out
);
  logic [7:0] float_q = 8'h00;
  always_ff @(posedge clk_in) float_q <= ~float_q;
  assign pin_out = ~press_in & (pullup_in | float_q);
endmodule : pfkbi_keys

// >>> pfkbi_bench.sv
// Self-checking bench for the port F keypad interrupt block.
// Assumes pfkbi_pkg, pfkbi_top, pfkbi_keys and the bound checker.
`timescale 1ns/1ps
module pfkbi_bench;
  import pfkbi_pkg::*;
  localparam logic [3:0] SC = ADDR_STATUS_CONTROL;
  // Rows: address, write data, read-back
  localparam logic [19:0] ROWS [8] = '{20'h8_A5A5, 20'h8_FFFF, 20'hC_0F0F, 20'h4_A5A5,
    20'h4_0000, 20'h0_F703, 20'h0_0000, 20'h2_FF00};
  logic        clk, rst, rd, wr, vf, brk, bce, wq;
  logic [3:0]  adr;
  logic [31:0] wd, rdata, rv;
  logic [7:0]  keys, pin, pu, oe;
  pfkbi_cpu_s  cpu;
  int          error_cnt = 0;
  int          total_checks = 0;
  pfkbi_top pfkbi_top_inst (.CLK_IN(clk), .SYS_RST_IN(rst), .AVS_ADDRESS_IN(adr),
    .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd), .AVS_BYTEENABLE_IN(4'hF),
    .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wq), .VECTOR_FETCH_IN(vf),
    .BREAK_STATE_IN(brk), .BREAK_CLEAR_ENABLE_IN(bce), .CPU_OUT(cpu), .PIN_IN(pin),
    .PIN_PULLUP_OUT(pu), .PIN_OUTPUT_ENABLE_OUT(oe));
  pfkbi_keys pfkbi_keys_inst (.clk_in(clk), .press_in(keys), .pullup_in(pu), .pin_out(pin));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (4000) @(posedge clk);
    error_cnt++;
    results();
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    adr <= a;
    wd <= {24'h0, d};
    wr <= w;
    rd <= ~w;
    do @(posedge clk); while (wq !== 1'b0);
    rv = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(rv, {24'h0, e});
  endtask : rchk
  task automatic see(input logic e);
    repeat (6) @(negedge clk);
    chk(32'(cpu.irq), 32'(e));
    @(posedge clk);
  endtask : see
  task automatic pulse();
    vf <= 1'b1;
    @(posedge clk);
    vf <= 1'b0;
  endtask : pulse
  task automatic results();
    if (error_cnt == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results
  initial begin
    {rst, rd, wr, vf, brk, bce, adr, wd, keys} = {1'b1, 50'h0};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    foreach (ROWS[i]) begin
      bus(1'b1, ROWS[i][19:16], ROWS[i][15:8]);
      rchk(ROWS[i][19:16], ROWS[i][7:0]);
    end
    bus(1'b1, SC, 8'h02);
    bus(1'b1, 4'h4, 8'h03);
    @(negedge clk);
    chk(32'(oe), 32'hC);
    chk(32'(pu), 32'hFF);
    bus(1'b1, SC, 8'h06);
    bus(1'b1, SC, 8'h00);
    keys <= 8'h01;
    see(1'b1);
    bus(1'b1, SC, 8'h02);
    see(1'b0);
    rchk(SC, 8'h0A);
    bus(1'b1, SC, 8'h04);
    see(1'b0);
    keys <= 8'h03;
    see(1'b0);
    keys <= 8'h00;
    see(1'b0);
    keys <= 8'h02;
    see(1'b1);
    pulse();
    see(1'b0);
    bus(1'b1, SC, 8'h01);
    see(1'b1);
    pulse();
    see(1'b1);
    keys <= 8'h00;
    see(1'b0);
    bus(1'b1, SC, 8'h00);
    keys <= 8'h02;
    see(1'b1);
    keys <= 8'h00;
    brk <= 1'b1;
    bus(1'b1, SC, 8'h04);
    see(1'b1);
    bce <= 1'b1;
    bus(1'b1, SC, 8'h04);
    see(1'b0);
    {brk, bce} <= 2'b00;
    see(1'b0);
    bus(1'b1, SC, 8'h01);
    keys <= 8'h01;
    see(1'b1);
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    see(1'b0);
    rchk(SC, 8'h00);
    rchk(4'h8, 8'hFF);
    results();
  end
endmodule : pfkbi_bench
